// ### msw_pkg.sv
// How it works
// R1 - four decision flags in top nibble
// R2 - vector limit flag only 16x16, main partition
// R3 - five early-exit flags at 27:23
// R4 - early-exit flags only when early exit allowed
// R5 - seven sub-function flags at 22:16
// R6 - 8x8 partition gives four quadrant pred modes
// R7 - larger partitions fill used modes, zero rest
// R8 - shape byte only for 8x8, else zero
// R9 - count distinct second-path search units, 0..48
// R10 - stall clocks by 16, 10 bits, saturate
// R11 - compute clocks by 16, saturate
// R12 - neighbour mask copied, reserved bits zero
// R13 - luma modes as four 16-bit groups
// R14 - 16x16 intra mode in slot 0 low bits
// R15 - one direct bit per quadrant, B slices only; resW3 carries them for all slices, only directUsed is gated by bSlice
// R16 - best intra cost 14 bits, 27:14 zero
// R17 - placement matches pack object command layout
// R18 - all reserved result bits zero
package msw_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_W3 = 8'h04;
  localparam logic [7:0] ADDR_W4 = 8'h08;
  localparam logic [7:0] ADDR_W5 = 8'h0C;
  localparam logic [7:0] ADDR_W6 = 8'h10;
  localparam logic [7:0] ADDR_W7 = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam int CTRL_EARLY_POS = 0;
  localparam int CTRL_SRC16_POS = 1;
  localparam int CTRL_DUAL_POS = 2;
  localparam int CTRL_NEIGH_POS = 8;
  localparam int CTRL_INTER_POS = 16;
  localparam int CTRL_INTRA_POS = 18;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h000F_FF07;
  localparam logic [7:0] NEIGH_MASK = 8'h3C;
  localparam logic [5:0] SU_MAX = 6'h30;
  localparam int DIV_SHIFT = 4;
  localparam int STALL_FIELD_W = 10;
  localparam int COMPUTE_FIELD_W = 8;
  localparam logic [1:0] INTER_16X16 = 2'h0;
  localparam logic [1:0] INTER_16X8 = 2'h1;
  localparam logic [1:0] INTER_8X16 = 2'h2;
  localparam logic [1:0] INTER_8X8 = 2'h3;
  localparam logic [1:0] INTRA_16X16 = 2'h0;
  localparam logic [1:0] INTRA_8X8 = 2'h1;
  localparam logic [1:0] INTRA_4X4 = 2'h2;
  typedef enum logic [1:0] {
    MSW_IDLE = 2'b01,
    MSW_BUSY = 2'b10
  } msw_state_t;
endpackage : msw_pkg

// ### msw_stat_if.sv
interface msw_stat_if;
  import msw_pkg::*;
  logic clear;
  logic run;
  logic stall;
  logic [STALL_FIELD_W-1:0] stallField;
  logic [COMPUTE_FIELD_W-1:0] computeField;
  modport eng (output clear, output run, output stall, input stallField, input computeField);
  modport stat (input clear, input run, input stall, output stallField, output computeField);
endinterface : msw_stat_if

// ### msw_clock_stats.sv
module msw_clock_stats
  import msw_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  msw_stat_if.stat st
);
  localparam int SW = STALL_FIELD_W + DIV_SHIFT;
  localparam int CW = COMPUTE_FIELD_W + DIV_SHIFT;
  logic [SW-1:0] stallCnt;
  logic [CW-1:0] computeCnt;
  wire stallInc = st.run && st.stall && !(&stallCnt);
  wire computeInc = st.run && !st.stall && !(&computeCnt);

  // raw counts saturate, so the reported field sticks at its maximum
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stallCnt <= '0;
      computeCnt <= '0;
    end else if (st.clear) begin
      stallCnt <= '0;
      computeCnt <= '0;
    end else begin
      if (stallInc) stallCnt <= stallCnt + 1'b1; // see R10
      if (computeInc) computeCnt <= computeCnt + 1'b1; // see R11
    end
  end

  assign st.stallField = stallCnt[SW-1:DIV_SHIFT];
  assign st.computeField = computeCnt[CW-1:DIV_SHIFT];

  AST_STAT_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    st.clear |=> (st.stallField == '0) && (st.computeField == '0)) // see R10
    else $error("clock stats not cleared at request start");
  AST_STAT_SAT: assert property (@(posedge core_clk) disable iff (!nrst)
    (&st.stallField) && !st.clear |=> (&st.stallField)) // see R10
    else $error("stall field left saturation");
endmodule : msw_clock_stats

// ### msw_writeback.sv
// The AHB-Lite register port and the placing of the registers were left to the implementer.
module msw_writeback
  import msw_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic reqStart,
  input wire logic reqEnd,
  input wire logic engStall,
  input wire logic [3:0] rawDecisions,
  input wire logic [4:0] rawEarly,
  input wire logic [6:0] subFuncs,
  input wire logic [7:0] quadrantPredModes,
  input wire logic [7:0] quadrantShapes,
  input wire logic suVisit,
  input wire logic suSecondPath,
  input wire logic [5:0] suIndex,
  input wire logic [63:0] lumaIntraModes,
  input wire logic [3:0] quadrantDirectBits,
  input wire logic [13:0] bestIntraCost,
  output logic resultValid,
  output logic busy,
  output logic [31:0] resW3,
  output logic [31:0] resW4,
  output logic [31:0] resW5,
  output logic [31:0] resW6,
  output logic [31:0] resW7
);
  msw_state_t state;
  msw_state_t next_state;
  logic [31:0] ctrl;
  logic [7:0] addrQ;
  logic wrQ;
  logic [47:0] suSeen;
  logic [5:0] suCount;
  msw_stat_if stIf ();

  msw_clock_stats u_stats (
    .core_clk(core_clk),
    .nrst(nrst),
    .st(stIf)
  );

  // ---- AHB-Lite slave: zero wait states, always OKAY
  wire addrPhase = hsel && htrans[1] && hready;
  wire [7:0] addrIdx = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  function automatic logic [31:0] readMux(input logic [7:0] a, input logic [31:0] c,
      input logic [31:0] w3, input logic [31:0] w4, input logic [31:0] w5,
      input logic [31:0] w6, input logic [31:0] w7, input logic [31:0] s);
    case (a)
      ADDR_CTRL: readMux = c;
      ADDR_W3: readMux = w3;
      ADDR_W4: readMux = w4;
      ADDR_W5: readMux = w5;
      ADDR_W6: readMux = w6;
      ADDR_W7: readMux = w7;
      ADDR_STAT: readMux = s;
      default: readMux = 32'h0000_0000;
    endcase
  endfunction : readMux

  wire [31:0] statusWord = {30'h0000_0000, resultValid, busy};
  wire [31:0] next_hrdata = readMux(addrIdx, ctrl, resW3, resW4, resW5, resW6, resW7, statusWord);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addrQ <= 8'h00;
      wrQ <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wrQ <= addrPhase && hwrite;
      if (addrPhase) addrQ <= addrIdx;
      if (addrPhase && !hwrite) hrdata <= next_hrdata;
    end
  end

  // only the control word is writable; writes elsewhere are dropped
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) ctrl <= CTRL_RESET;
    else if (wrQ && addrQ == ADDR_CTRL) ctrl <= hwdata & CTRL_WMASK;
  end

  wire earlyAllow = ctrl[CTRL_EARLY_POS];
  wire src16 = ctrl[CTRL_SRC16_POS];
  wire dualPath = ctrl[CTRL_DUAL_POS];
  wire [7:0] neighReq = ctrl[CTRL_NEIGH_POS +: 8];
  wire [1:0] interMode = ctrl[CTRL_INTER_POS +: 2];
  wire [1:0] intraMode = ctrl[CTRL_INTRA_POS +: 2];

  // ---- request sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      MSW_IDLE: if (reqStart) next_state = MSW_BUSY;
      MSW_BUSY: if (reqEnd) next_state = MSW_IDLE;
      default: next_state = MSW_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) state <= MSW_IDLE;
    else state <= next_state;
  end

  assign busy = (state == MSW_BUSY);
  assign stIf.clear = (state == MSW_IDLE) && reqStart;
  assign stIf.run = busy;
  assign stIf.stall = engStall;

  // ---- distinct second-path search units; revisits hit the seen map
  wire suNew = busy && dualPath && suVisit && suSecondPath && (suIndex < SU_MAX) && !suSeen[suIndex];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      suSeen <= '0;
      suCount <= 6'h00;
    end else if (stIf.clear) begin
      suSeen <= '0;
      suCount <= 6'h00;
    end else if (suNew) begin
      suSeen[suIndex] <= 1'b1;
      suCount <= suCount + 6'h01; // see R9
    end
  end

  // ---- result assembly, one field per continuous assignment
  wire limitFlag = rawDecisions[3] && src16; // see R2
  wire [3:0] decisionBits = {limitFlag, rawDecisions[2:0]}; // see R1
  wire [4:0] earlyBits = earlyAllow ? rawEarly : 5'h00; // see R3 R4
  wire [7:0] predMask = (interMode == INTER_8X8) ? 8'hFF :
                        (interMode == INTER_16X16) ? 8'h03 : 8'h0F;
  wire [7:0] predField = quadrantPredModes & predMask; // see R6 R7
  wire [7:0] shapeField = (interMode == INTER_8X8) ? quadrantShapes : 8'h00; // see R8
  wire [5:0] suField = dualPath ? suCount : 6'h00; // see R9
  wire [7:0] neighField = neighReq & NEIGH_MASK; // see R12 R18

  // 16x16 intra has four modes only; 8x8 uses just group 0
  wire [63:0] lumaMask = (intraMode == INTRA_16X16) ? 64'h0000_0000_0000_0003 :
                         (intraMode == INTRA_8X8) ? 64'h0000_0000_0000_FFFF :
                         (intraMode == INTRA_4X4) ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0;
  wire [63:0] lumaField = lumaIntraModes & lumaMask; // see R13 R14

  // placement follows the pack object inline data so software forwards it
  wire [31:0] next_w7 = {decisionBits, earlyBits, subFuncs, predField, shapeField}; // see R5 R17
  wire [31:0] next_w6 = {suField, stIf.stallField, stIf.computeField, neighField}; // see R10 R11
  wire [31:0] next_w5 = lumaField[63:32];
  wire [31:0] next_w4 = lumaField[31:0];
  wire [31:0] next_w3 = {quadrantDirectBits, 14'h0000, bestIntraCost}; // see R15 R16 R18

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resW3 <= 32'h0000_0000;
      resW4 <= 32'h0000_0000;
      resW5 <= 32'h0000_0000;
      resW6 <= 32'h0000_0000;
      resW7 <= 32'h0000_0000;
      resultValid <= 1'b0;
    end else if (busy && reqEnd) begin
      resW3 <= next_w3;
      resW4 <= next_w4;
      resW5 <= next_w5;
      resW6 <= next_w6;
      resW7 <= next_w7;
      resultValid <= 1'b1;
    end else if (stIf.clear) begin
      resultValid <= 1'b0;
    end
  end

  // ---- checks
  wire done = busy && reqEnd;

  AST_LIMIT_SRC: assert property (@(posedge core_clk) disable iff (!nrst)
    done && !src16 |=> !resW7[31]) // see R2
    else $error("vector limit flag set for non 16x16 source");
  AST_DECISIONS: assert property (@(posedge core_clk) disable iff (!nrst)
    done |=> resW7[30:28] == $past(rawDecisions[2:0])) // see R1
    else $error("decision flags not reported");
  AST_EARLY_GATE: assert property (@(posedge core_clk) disable iff (!nrst)
    done && !earlyAllow |=> resW7[27:23] == 5'h00) // see R4
    else $error("early exit flags set while not allowed");
  AST_EARLY_PASS: assert property (@(posedge core_clk) disable iff (!nrst)
    done && earlyAllow |=> resW7[27:23] == $past(rawEarly)) // see R3
    else $error("early exit flags lost");
  AST_SUBFUNC: assert property (@(posedge core_clk) disable iff (!nrst)
    done |=> resW7[22:16] == $past(subFuncs)) // see R5
    else $error("sub-function flags wrong");
  AST_PRED_16: assert property (@(posedge core_clk) disable iff (!nrst)
    done && interMode == INTER_16X16 |=> resW7[15:10] == 6'h00) // see R7
    else $error("unused prediction mode bits not zero");
  AST_PRED_8X8: assert property (@(posedge core_clk) disable iff (!nrst)
    done && interMode == INTER_8X8 |=> resW7[15:0] == $past({quadrantPredModes, quadrantShapes})) // see R6
    else $error("8x8 quadrant fields wrong");
  AST_SHAPE_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
    done && interMode != INTER_8X8 |=> resW7[7:0] == 8'h00) // see R8
    else $error("shape byte not zero");
  AST_SU_RANGE: assert property (@(posedge core_clk) disable iff (!nrst)
    suCount <= SU_MAX) // see R9
    else $error("search unit count above range");
  AST_SU_SINGLE: assert property (@(posedge core_clk) disable iff (!nrst)
    done && !dualPath |=> resW6[31:26] == 6'h00) // see R9
    else $error("second path count nonzero on single path");
  AST_NEIGH: assert property (@(posedge core_clk) disable iff (!nrst)
    done |=> resW6[7:0] == ($past(neighReq) & NEIGH_MASK)) // see R12
    else $error("neighbour mask not copied");
  AST_INTRA16: assert property (@(posedge core_clk) disable iff (!nrst)
    done && intraMode == INTRA_16X16 |=> resW4[31:2] == 30'h0 && resW5 == 32'h0) // see R14
    else $error("16x16 intra mode slot not isolated");
  AST_W3_LAYOUT: assert property (@(posedge core_clk) disable iff (!nrst)
    done |=> resW3 == {$past(quadrantDirectBits), 14'h0000, $past(bestIntraCost)}) // see R15 R16
    else $error("direct bits or intra cost misplaced");
  AST_LUMA_4X4: assert property (@(posedge core_clk) disable iff (!nrst) // see R13
    done && intraMode == INTRA_4X4 |=> {resW5, resW4} == $past(lumaIntraModes))
    else $error("4x4 luma modes not packed");
  AST_STATS: assert property (@(posedge core_clk) disable iff (!nrst) // see R10 R11
    done |=> resW6[25:8] == $past({stIf.stallField, stIf.computeField}))
    else $error("clock statistics misplaced");
  AST_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    !done |=> $stable(resW7) && $stable(resW3)) // see R17
    else $error("result changed without request end");

  COV_8X8: cover property (@(posedge core_clk) disable iff (!nrst) done && interMode == INTER_8X8);
  COV_EARLY: cover property (@(posedge core_clk) disable iff (!nrst) done && earlyAllow && (|rawEarly));
  COV_DUAL: cover property (@(posedge core_clk) disable iff (!nrst) done && dualPath && suCount != 6'h00);
  COV_READ: cover property (@(posedge core_clk) disable iff (!nrst) addrPhase && !hwrite && addrIdx == ADDR_W7);
  COV_SAT: cover property (@(posedge core_clk) disable iff (!nrst) done && (&stIf.stallField));
endmodule : msw_writeback

// ### msw_result_sink.sv
module msw_result_sink (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic resultValid,
  input wire logic bSlice,
  input wire logic [31:0] resW3,
  output logic [3:0] directUsed,
  output int nMsgs
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen;
  // one message per rise of resultValid; a level held over several cycles is not recounted
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seen <= 1'b0;
      directUsed <= 4'h0;
      nMsgs <= 0;
    end else begin
      seen <= resultValid;
      if (resultValid && !seen) begin
        nMsgs <= nMsgs + 1;
        directUsed <= bSlice ? resW3[31:28] : 4'h0;
      end
    end
  end
endmodule : msw_result_sink

// ### msw_writeback_tb.sv
module msw_writeback_tb import msw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, nrst = 0, hsel = 0, hwrite = 0, reqStart = 0, reqEnd = 0, engStall = 0;
  logic suVisit = 0, suSecondPath = 0, bSlice = 0, hreadyout, hresp, resultValid, busy;
  logic [1:0] htrans = 2'h0;
  logic [5:0] suIndex = 6'h00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, ctrl;
  logic [31:0] ex [5];
  logic [3:0] directUsed;
  logic [3:0] rawDecisions = 4'h0, quadrantDirectBits = 4'h0;
  logic [4:0] rawEarly = 5'h00;
  logic [6:0] subFuncs = 7'h00;
  wire [31:0] resW [5];
  int n_fail = 0, checks_done = 0, nMsgs, st, cp;
  msw_writeback DUT (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .reqStart(reqStart), .reqEnd(reqEnd), .engStall(engStall),
    .rawDecisions(rawDecisions), .rawEarly(rawEarly), .subFuncs(subFuncs), .quadrantPredModes(8'hE4),
    .quadrantShapes(8'h1B), .suVisit(suVisit), .suSecondPath(suSecondPath), .suIndex(suIndex),
    .lumaIntraModes(64'h9876_5432_1FED_CBA9), .quadrantDirectBits(quadrantDirectBits), .bestIntraCost(14'h2ABC),
    .resultValid(resultValid), .busy(busy), .resW3(resW[0]), .resW4(resW[1]), .resW5(resW[2]),
    .resW6(resW[3]), .resW7(resW[4]));
  msw_result_sink SINK (.core_clk(core_clk), .nrst(nrst), .resultValid(resultValid), .bSlice(bSlice),
    .resW3(resW[0]), .directUsed(directUsed), .nMsgs(nMsgs));
  always #20 core_clk = ~core_clk;

  task complete_run;
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  // waits one bus edge with hready high; a stuck bus ends the run
  task automatic wait_ready;
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask : wait_ready

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    ahb(ADDR_CTRL, 0, 0, rd);
    chk("ctrl reset", CTRL_RESET, rd);
    ahb(ADDR_CTRL, 1, 32'hFFFF_FFFF, rd);
    ahb(ADDR_CTRL, 0, 0, rd);
    chk("ctrl mask", 32'h000F_FF07, rd);
    ahb(8'h1C, 0, 0, rd);
    chk("unmapped", 32'h0, rd);
    for (int m = 0; m < 4; m++) begin
      // inter mode m with intra mode 3-m sets every code of both fields once
      ctrl = {12'h0, 2'(3 - m), 2'(m), 8'hFF, 5'h0, 1'(m != 0), 1'(m >> 1), 1'(m)};
      st = (m == 3) ? 16500 : 40;
      cp = (m == 3) ? 4200 : 100;
      bSlice <= 1'(m);
      // raw engine flags change per pass so swapped or stuck bits show up
      rawDecisions <= {1'b1, 3'(m + 4)};
      rawEarly <= 5'(5'h15 + m);
      subFuncs <= 7'(7'h55 >> m);
      quadrantDirectBits <= 4'(m + 9);
      ahb(ADDR_CTRL, 1, ctrl, rd);
      reqStart <= 1'b1;
      @(posedge core_clk);
      reqStart <= 1'b0;
      #1;
      chk("busy", 32'h1, {31'h0, busy});
      chk("valid drop", 32'h0, {31'h0, resultValid});
      @(posedge core_clk);
      engStall <= 1'b1;
      repeat (st) @(posedge core_clk);
      engStall <= 1'b0;
      // indices 48..63 and revisits must not add to the unit count
      for (int i = 0; i < cp; i++) begin
        suVisit <= (i < 100);
        suSecondPath <= 1'b1;
        suIndex <= 6'(i % 64);
        @(posedge core_clk);
      end
      suVisit <= 1'b0;
      reqEnd <= 1'b1;
      @(posedge core_clk);
      reqEnd <= 1'b0;
      for (int k = 0; resultValid !== 1'b1; k++) begin
        if (k > 20) begin
          n_fail++;
          complete_run();
        end
        @(posedge core_clk);
      end
      ex[0] = {4'(m + 9), 14'h0, 14'h2ABC};
      ex[1] = (m == 1) ? 32'h1FED_CBA9 : (m == 2) ? 32'h0000_CBA9 : {31'h0, m == 3};
      ex[2] = (m == 1) ? 32'h9876_5432 : 32'h0;
      ex[3] = {(m != 0) ? 6'd48 : 6'd0, (m == 3) ? 10'd1023 : 10'd2, (m == 3) ? 8'd255 : 8'd6, 8'h3C};
      ex[4] = {1'(m > 1), 3'(m + 4), m[0] ? 5'(5'h15 + m) : 5'h00, 7'(7'h55 >> m),
        m == 0 ? 8'h00 : m < 3 ? 8'h04 : 8'hE4, m == 3 ? 8'h1B : 8'h00};
      @(posedge core_clk);
      for (int i = 0; i < 5; i++) begin
        ahb(ADDR_W3 + 8'(4 * i), 0, 0, rd);
        chk("result word", ex[i], rd);
        chk("result port", ex[i], resW[i]);
      end
      ahb(ADDR_STAT, 0, 0, rd);
      chk("status", 32'h2, rd);
      chk("direct used", m[0] ? 32'(m + 9) : 32'h0, {28'h0, directUsed});
      chk("messages", 32'(m + 1), 32'(nMsgs));
    end
    complete_run();
  end
endmodule : msw_writeback_tb
